//--- design/psq_pkg.sv
package psq_pkg;
  // clock and derived millisecond prescale
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int MS_W = 11;
  // chosen times in ms, each inside its documented window
  localparam logic [10:0] ACG_ON_MS = 11'h032;
  localparam logic [10:0] MAIN_HOLD_MS = 11'h007;
  localparam logic [10:0] AUX_HOLD_MS = 11'h00F;
  localparam logic [10:0] OFF_MIN_MS = 11'h3E8;
  localparam logic [10:0] MAIN_DLY_MS = 11'h00F;
  localparam logic [10:0] PSON_OFF_MS = 11'h005;
  localparam logic [10:0] BLINK_SLOT_MS = 11'h0FA;
  localparam logic [2:0] BLINK_SLOTS = 3'h6;
  // current share
  localparam int SHARE_BITS = 8;
  localparam logic [3:0] SHARE_LAST = 4'h8;
  localparam int TRIM_LIMIT_MV = 250;
  localparam int TRIM_STEP_MV = 25;
  localparam logic [3:0] TRIM_MAX = 4'(TRIM_LIMIT_MV / TRIM_STEP_MV);
  // wishbone map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int CTRL_GRANT_BIT = 0;
  // synchroniser reset: enable pin idles high through its pull-up
  localparam logic [16:0] SYNC_RST = 17'h00002;
  typedef enum logic [1:0] {M_OFF, M_DLY, M_ON, M_STOP} psq_main_type;
  typedef enum logic [2:0] {P_OFF, P_GREEN, P_YEL, P_Y11, P_YG12, P_YG21, P_YG11} psq_pat_type;
endpackage

//--- design/psq_top.sv
`timescale 1ns/100ps
module psq_ms_cnt #(
  parameter int W = 11
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic clr_i,
  output logic [W-1:0] cnt_o
);
  // saturating millisecond counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_o <= '0;
    end else if (ce_i) begin
      if (clr_i) begin
        cnt_o <= '0;
      end else if (tick_i && !(&cnt_o)) begin
        cnt_o <= cnt_o + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module psq_top #(
  parameter int CYC_PER_MS = psq_pkg::CYC_PER_MS,
  parameter logic [10:0] BLINK_SLOT_MS = psq_pkg::BLINK_SLOT_MS
) (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic CLKEN_I,
  input wire logic [3:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  input wire logic AC_IN_RANGE_I,
  input wire logic MAIN_OUTPUT_ENABLE_N_I,
  input wire logic UNPLUG_KILL_I,
  input wire logic STANDBY_PERMIT_I,
  input wire logic SHARE_BUS_I,
  input wire logic MAIN_OK_I,
  input wire logic AUX_OK_I,
  input wire logic OT_SHDN_I,
  input wire logic OV_SHDN_I,
  input wire logic OC_SHDN_I,
  input wire logic FAN_MAJOR_I,
  input wire logic OT_WARN_I,
  input wire logic FAN_MINOR_I,
  input wire logic SENSE_SHORT_I,
  input wire logic AUX_ILIM_I,
  input wire logic AUX_UV_I,
  input wire logic LOAD_LOW_I,
  input wire logic [7:0] LOAD_CUR_I,
  output logic AC_LED_O,
  output logic DC_LED_GREEN_O,
  output logic DC_LED_YELLOW_O,
  output logic AUX_RAIL_EN_O,
  output logic MAIN_RAIL_EN_O,
  output logic AC_GOOD_O,
  output logic POWER_GOOD_OUT_O,
  output logic POWER_GOOD_OE_O,
  output logic PLUGGED_IN_N_O,
  output logic STANDBY_PERMIT_OUT_O,
  output logic STANDBY_PERMIT_OE_O,
  output logic SHARE_BUS_OUT_O,
  output logic SHARE_BUS_OE_O,
  output logic [3:0] TRIM_O
);
  localparam int PRE_W = $clog2(CYC_PER_MS);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

  logic [16:0] sync1_r;
  logic [16:0] sync2_r;
  logic ac_ok, pson_n, kill, permit, share_s, main_ok, aux_ok, ot_sd, ov_sd, oc_sd;
  logic fan_maj, ot_warn, fan_min, sense_sc, aux_ilim, aux_uv, load_low;
  logic [PRE_W-1:0] pre_r;
  logic tick;
  logic [10:0] ac_ok_ms, ac_lost_ms, aux_off_ms, main_off_ms, dly_ms, slot_ms;
  logic aux_on_r, ac_good_r, ac_led_r, fault_r, sense_flt_r, pson_d_r;
  logic standby_r, was_stby_r, main_en_r, grant_r;
  psq_pkg::psq_main_type main_r, main_nxt;
  psq_pkg::psq_pat_type pat_r;
  logic [2:0] slot_r;
  logic led_y_r, led_g_r;
  logic [3:0] sh_idx_r, trim_r;
  logic [7:0] cur_r, rx_r;
  logic lost_r, master_r, share_oe_r;
  logic pson_en, aux_lim, shut_evt, pson_rise, main_req, main_stop, slot_end;
  logic share_act, rail_bad, hard_bad, pg_ok, stby_ok, ack_r;
  logic [31:0] rdat_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      sync1_r <= psq_pkg::SYNC_RST;
      sync2_r <= psq_pkg::SYNC_RST;
    end else if (CLKEN_I) begin
      sync1_r <= {LOAD_LOW_I, AUX_UV_I, AUX_ILIM_I, SENSE_SHORT_I, FAN_MINOR_I, OT_WARN_I,
                  FAN_MAJOR_I, OC_SHDN_I, OV_SHDN_I, OT_SHDN_I, AUX_OK_I, MAIN_OK_I,
                  SHARE_BUS_I, STANDBY_PERMIT_I, UNPLUG_KILL_I, MAIN_OUTPUT_ENABLE_N_I,
                  AC_IN_RANGE_I};
      sync2_r <= sync1_r;
    end
  end
  assign {load_low, aux_uv, aux_ilim, sense_sc, fan_min, ot_warn, fan_maj, oc_sd, ov_sd,
          ot_sd, aux_ok, main_ok, share_s, permit, kill, pson_n, ac_ok} = sync2_r;

  assign pson_en = !pson_n;
  assign aux_lim = aux_ilim && aux_uv;
  assign shut_evt = ot_sd || ov_sd || oc_sd || fan_maj;
  assign pson_rise = pson_d_r && pson_en;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base and timers
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      pre_r <= '0;
    end else if (CLKEN_I) begin
      pre_r <= (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
    end
  end
  assign tick = (pre_r == PRE_LAST);
  assign slot_end = tick && (slot_ms >= BLINK_SLOT_MS - 11'h001);

  psq_ms_cnt u_ac_ok (.clk_i(CLOCK_I), .srst_i(SRST_I), .ce_i(CLKEN_I), .tick_i(tick),
    .clr_i(!ac_ok), .cnt_o(ac_ok_ms));
  psq_ms_cnt u_ac_lost (.clk_i(CLOCK_I), .srst_i(SRST_I), .ce_i(CLKEN_I), .tick_i(tick),
    .clr_i(ac_ok), .cnt_o(ac_lost_ms));
  psq_ms_cnt u_aux_off (.clk_i(CLOCK_I), .srst_i(SRST_I), .ce_i(CLKEN_I), .tick_i(tick),
    .clr_i(aux_on_r), .cnt_o(aux_off_ms));
  psq_ms_cnt u_main_off (.clk_i(CLOCK_I), .srst_i(SRST_I), .ce_i(CLKEN_I), .tick_i(tick),
    .clr_i(main_en_r), .cnt_o(main_off_ms));
  psq_ms_cnt u_dly (.clk_i(CLOCK_I), .srst_i(SRST_I), .ce_i(CLKEN_I), .tick_i(tick),
    .clr_i(main_nxt != main_r), .cnt_o(dly_ms));
  psq_ms_cnt u_slot (.clk_i(CLOCK_I), .srst_i(SRST_I), .ce_i(CLKEN_I), .tick_i(tick),
    .clr_i(slot_end), .cnt_o(slot_ms));

  ////////////////////////////////////////////////////////////////////////////
  // ac_good, latched faults, aux rail
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ac_good_r <= 1'b0;
      ac_led_r <= 1'b0;
    end else if (CLKEN_I) begin
      ac_led_r <= ac_ok;
      ac_good_r <= ac_ok && (ac_ok_ms >= psq_pkg::ACG_ON_MS);
    end
  end

  // set wins over the enable toggle or an AC loss deep enough to drop aux
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      fault_r <= 1'b0;
      sense_flt_r <= 1'b0;
      pson_d_r <= 1'b0;
    end else if (CLKEN_I) begin
      pson_d_r <= !pson_en;
      if (shut_evt || sense_sc) begin
        fault_r <= 1'b1;
      end else if (pson_rise || ac_lost_ms > psq_pkg::AUX_HOLD_MS) begin
        fault_r <= 1'b0;
      end
      if (sense_sc) begin
        sense_flt_r <= 1'b1;
      end else if (pson_rise || ac_lost_ms > psq_pkg::AUX_HOLD_MS) begin
        sense_flt_r <= 1'b0;
      end
    end
  end

  // aux ignores unplug kill; holds up 15 ms past AC loss
  // first tick may come at once, so n ticks only prove n-1 ms: compare strictly
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      aux_on_r <= 1'b0;
    end else if (CLKEN_I) begin
      if (sense_flt_r || ac_lost_ms > psq_pkg::AUX_HOLD_MS) begin
        aux_on_r <= 1'b0;
      end else if (!aux_on_r && ac_ok && aux_off_ms > psq_pkg::OFF_MIN_MS) begin
        aux_on_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main rail sequencer
  assign main_req = aux_on_r && ac_ok && pson_en && !kill && !fault_r && !aux_lim
                    && !standby_r;
  assign main_stop = kill || fault_r || aux_lim || standby_r || !aux_on_r
                     || (ac_lost_ms > psq_pkg::MAIN_HOLD_MS);

  always_comb begin
    main_nxt = main_r;
    unique case (main_r)
      psq_pkg::M_OFF: begin
        if (main_req && (main_off_ms > psq_pkg::OFF_MIN_MS || was_stby_r)) begin
          main_nxt = psq_pkg::M_DLY;
        end
      end
      psq_pkg::M_DLY: begin
        if (!main_req) begin
          main_nxt = psq_pkg::M_OFF;
        end else if (dly_ms >= psq_pkg::MAIN_DLY_MS) begin
          main_nxt = psq_pkg::M_ON;
        end
      end
      psq_pkg::M_ON: begin
        if (main_stop) begin
          main_nxt = psq_pkg::M_OFF;
        end else if (!pson_en) begin
          main_nxt = psq_pkg::M_STOP;
        end
      end
      psq_pkg::M_STOP: begin
        if (main_stop) begin
          main_nxt = psq_pkg::M_OFF;
        end else if (pson_en) begin
          main_nxt = psq_pkg::M_ON;
        end else if (dly_ms >= psq_pkg::PSON_OFF_MS) begin
          main_nxt = psq_pkg::M_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      main_r <= psq_pkg::M_OFF;
      main_en_r <= 1'b0;
    end else if (CLKEN_I) begin
      main_r <= main_nxt;
      main_en_r <= (main_nxt == psq_pkg::M_ON) || (main_nxt == psq_pkg::M_STOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hot standby; leaving it restarts main without the 1 s off wait
  assign stby_ok = grant_r && permit && load_low && !fault_r && !sense_flt_r;
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      standby_r <= 1'b0;
      was_stby_r <= 1'b0;
    end else if (CLKEN_I) begin
      if (!stby_ok) begin
        standby_r <= 1'b0;
      end else if (main_r == psq_pkg::M_ON) begin
        standby_r <= 1'b1;
      end
      if (standby_r) begin
        was_stby_r <= 1'b1;
      end else if (main_en_r) begin
        was_stby_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DC LED priority and blink slots
  assign rail_bad = (main_en_r && !main_ok) || (aux_on_r && !aux_ok);
  assign hard_bad = rail_bad || fault_r || sense_flt_r || shut_evt;

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      pat_r <= psq_pkg::P_OFF;
    end else if (CLKEN_I) begin
      if (pson_n) begin
        pat_r <= psq_pkg::P_Y11;
      end else if (standby_r) begin
        pat_r <= psq_pkg::P_YG12;
      end else if (hard_bad) begin
        pat_r <= psq_pkg::P_YEL;
      end else if (ot_warn) begin
        pat_r <= psq_pkg::P_YG21;
      end else if (fan_min) begin
        pat_r <= psq_pkg::P_YG11;
      end else if (main_en_r) begin
        pat_r <= psq_pkg::P_GREEN;
      end else begin
        pat_r <= psq_pkg::P_OFF;
      end
    end
  end

  // six slots of one period give every documented ratio
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      slot_r <= 3'h0;
      led_y_r <= 1'b0;
      led_g_r <= 1'b0;
    end else if (CLKEN_I) begin
      if (slot_end) begin
        slot_r <= (slot_r == psq_pkg::BLINK_SLOTS - 3'h1) ? 3'h0 : slot_r + 3'h1;
      end
      unique case (pat_r)
        psq_pkg::P_OFF: begin
          led_y_r <= 1'b0;
          led_g_r <= 1'b0;
        end
        psq_pkg::P_GREEN: begin
          led_y_r <= 1'b0;
          led_g_r <= 1'b1;
        end
        psq_pkg::P_YEL: begin
          led_y_r <= 1'b1;
          led_g_r <= 1'b0;
        end
        psq_pkg::P_Y11: begin
          led_y_r <= (slot_r < 3'h3);
          led_g_r <= 1'b0;
        end
        psq_pkg::P_YG12: begin
          led_y_r <= (slot_r < 3'h2);
          led_g_r <= (slot_r >= 3'h2);
        end
        psq_pkg::P_YG21: begin
          led_y_r <= (slot_r < 3'h4);
          led_g_r <= (slot_r >= 3'h4);
        end
        psq_pkg::P_YG11: begin
          led_y_r <= (slot_r < 3'h3);
          led_g_r <= (slot_r >= 3'h3);
        end
        default: begin
          led_y_r <= 1'b0;
          led_g_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current share: bitwise arbitration, dominant low, largest current wins
  assign share_act = main_en_r && !fault_r && !sense_flt_r;
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      sh_idx_r <= 4'h0;
      cur_r <= 8'h00;
      rx_r <= 8'h00;
      lost_r <= 1'b0;
      master_r <= 1'b0;
      trim_r <= 4'h0;
      share_oe_r <= 1'b0;
    end else if (CLKEN_I) begin
      if (!share_act) begin
        sh_idx_r <= psq_pkg::SHARE_LAST;
        lost_r <= 1'b0;
        master_r <= 1'b0;
        trim_r <= 4'h0;
        share_oe_r <= 1'b0;
      end else begin
        share_oe_r <= (sh_idx_r < psq_pkg::SHARE_LAST) && !lost_r
                      && cur_r[3'(psq_pkg::SHARE_BITS - 1) - sh_idx_r[2:0]];
        if (tick) begin
          if (sh_idx_r == psq_pkg::SHARE_LAST) begin
            sh_idx_r <= 4'h0;
            cur_r <= LOAD_CUR_I;
            lost_r <= 1'b0;
          end else begin
            sh_idx_r <= sh_idx_r + 4'h1;
            rx_r <= {rx_r[6:0], !share_s};
            if (!share_s && !cur_r[3'(psq_pkg::SHARE_BITS - 1) - sh_idx_r[2:0]]) begin
              lost_r <= 1'b1;
            end
            if (sh_idx_r == psq_pkg::SHARE_LAST - 4'h1) begin
              master_r <= !lost_r && !(!share_s && !cur_r[0]);
            end
          end
          if (sh_idx_r == psq_pkg::SHARE_LAST) begin
            if (!master_r && cur_r < rx_r && trim_r < psq_pkg::TRIM_MAX) begin
              trim_r <= trim_r + 4'h1;
            end else if ((master_r || cur_r > rx_r) && trim_r != 4'h0) begin
              trim_r <= trim_r - 4'h1;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, unmapped reads zero
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ack_r <= 1'b0;
      grant_r <= psq_pkg::CTRL_RST[psq_pkg::CTRL_GRANT_BIT];
      rdat_r <= 32'h00000000;
    end else if (CLKEN_I) begin
      ack_r <= CYC_I && STB_I && !ack_r;
      if (CYC_I && STB_I && !ack_r) begin
        if (WE_I && SEL_I[0] && ADR_I == psq_pkg::REG_CTRL) begin
          grant_r <= DAT_I[psq_pkg::CTRL_GRANT_BIT];
        end
        unique case (ADR_I)
          psq_pkg::REG_CTRL: rdat_r <= {31'h00000000, grant_r};
          psq_pkg::REG_STAT: rdat_r <= {17'h00000, pat_r, trim_r, master_r, standby_r,
                                        sense_flt_r, fault_r, pg_ok, main_en_r, aux_on_r,
                                        ac_good_r};
          default: rdat_r <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pg_ok = aux_on_r && main_en_r && aux_ok && main_ok;
  assign ACK_O = ack_r;
  assign DAT_O = rdat_r;
  assign AC_LED_O = ac_led_r;
  assign AC_GOOD_O = ac_good_r;
  assign DC_LED_YELLOW_O = led_y_r;
  assign DC_LED_GREEN_O = led_g_r;
  assign AUX_RAIL_EN_O = aux_on_r;
  assign MAIN_RAIL_EN_O = main_en_r;
  assign POWER_GOOD_OUT_O = 1'b0;
  assign POWER_GOOD_OE_O = !pg_ok;
  assign PLUGGED_IN_N_O = 1'b0;
  assign STANDBY_PERMIT_OUT_O = 1'b0;
  assign STANDBY_PERMIT_OE_O = fault_r || sense_flt_r;
  assign SHARE_BUS_OUT_O = 1'b0;
  assign SHARE_BUS_OE_O = share_oe_r;
  assign TRIM_O = trim_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I || !CLKEN_I);

  ac_led_a: assert property (ac_ok |=> AC_LED_O) else $error("ac led off in range");
  dc_prio_a: assert property (pson_n |=> pat_r == psq_pkg::P_Y11)
    else $error("disabled pattern lost");
  stby_pat_a: assert property (!pson_n && standby_r |=> pat_r == psq_pkg::P_YG12)
    else $error("standby pattern wrong");
  hard_pat_a: assert property (!pson_n && !standby_r && hard_bad |=> pat_r == psq_pkg::P_YEL)
    else $error("solid yellow missing");
  warn_pat_a: assert property (!pson_n && !standby_r && !hard_bad && ot_warn
    |=> pat_r == psq_pkg::P_YG21) else $error("warning pattern wrong");
  kill_main_a: assert property (kill |=> !MAIN_RAIL_EN_O) else $error("kill ignored");
  acg_drop_a: assert property (!ac_ok |=> !AC_GOOD_O) else $error("ac_good late");
  main_hold_a: assert property ($fell(AC_GOOD_O) && MAIN_RAIL_EN_O |-> ac_lost_ms < 11'h002)
    else $error("ac_good fell late vs holdup");
  off_min_a: assert property ($rose(AUX_RAIL_EN_O) |-> $past(aux_off_ms) > psq_pkg::OFF_MIN_MS)
    else $error("aux restarted early");
  on_dly_a: assert property ($rose(MAIN_RAIL_EN_O) |-> $past(dly_ms) >= psq_pkg::MAIN_DLY_MS)
    else $error("main on too early");
  pg_od_a: assert property (!POWER_GOOD_OE_O |-> MAIN_RAIL_EN_O && AUX_RAIL_EN_O)
    else $error("power good released with rail off");
  share_off_a: assert property (fault_r |=> !SHARE_BUS_OE_O)
    else $error("faulted unit on share bus");
  trim_lim_a: assert property (TRIM_O <= psq_pkg::TRIM_MAX) else $error("trim over limit");
  stby_exit_a: assert property (!permit |=> !standby_r) else $error("standby kept");
  ilim_a: assert property (aux_lim |=> !MAIN_RAIL_EN_O ##1 !MAIN_RAIL_EN_O)
    else $error("main not inhibited");

  main_on_c: cover property ($rose(MAIN_RAIL_EN_O));
  stby_c: cover property ($rose(standby_r));
  master_c: cover property ($rose(master_r));
  kill_c: cover property (MAIN_RAIL_EN_O ##1 kill ##1 !MAIN_RAIL_EN_O);
endmodule

//--- testbench/psq_peer.sv
`timescale 1ns/100ps
module psq_peer (
  input wire logic permit_oe_i,
  input wire logic share_oe_i,
  input wire logic fault_i,
  output logic permit_line_o,
  output logic share_line_o
);
  // wired permit line: pull-up, a faulted peer holds it low
  assign permit_line_o = ~(permit_oe_i | fault_i);
  // peer carries no load, so it stays off the share bus
  assign share_line_o = ~share_oe_i;
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int CPM = 10;
  localparam int PER = 6 * 2 * CPM;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, dat;
  logic ack, ac_led, aux, main, acg, pg_oe, pin_n, pm_oe, sh_oe, pm, sh;
  logic ac = 1'b0;
  logic en_n = 1'b1;
  logic kill = 1'b0;
  logic pflt = 1'b0;
  logic warn = 1'b0;
  logic fmin = 1'b0;
  logic low = 1'b0;
  logic [3:0] sd = 4'h0;
  logic ssc = 1'b0;
  logic ilim = 1'b0;
  logic uv = 1'b0;
  logic led_g, led_y, pg_out, pm_out, sh_out;
  logic [3:0] trim;
  logic [5:0] obs;
  int miscompares = 0;
  int tests_run = 0;
  assign obs = {pm_oe, sh_oe, acg, main, aux, ac_led};
  psq_top #(.CYC_PER_MS(CPM), .BLINK_SLOT_MS(11'h002)) i_psq_top (
    .CLOCK_I(clk), .SRST_I(rst), .CLKEN_I(1'b1), .ADR_I(adr), .DAT_I(wd), .DAT_O(dat),
    .WE_I(we), .SEL_I(4'hF), .CYC_I(stb), .STB_I(stb), .ACK_O(ack), .AC_IN_RANGE_I(ac),
    .MAIN_OUTPUT_ENABLE_N_I(en_n), .UNPLUG_KILL_I(kill), .STANDBY_PERMIT_I(pm),
    .SHARE_BUS_I(sh), .MAIN_OK_I(main), .AUX_OK_I(aux), .OT_SHDN_I(sd[0]), .OV_SHDN_I(sd[1]),
    .OC_SHDN_I(sd[2]), .FAN_MAJOR_I(sd[3]), .OT_WARN_I(warn), .FAN_MINOR_I(fmin),
    .SENSE_SHORT_I(ssc), .AUX_ILIM_I(ilim), .AUX_UV_I(uv), .LOAD_LOW_I(low),
    .LOAD_CUR_I(8'h40), .AC_LED_O(ac_led), .DC_LED_GREEN_O(led_g), .DC_LED_YELLOW_O(led_y),
    .AUX_RAIL_EN_O(aux), .MAIN_RAIL_EN_O(main), .AC_GOOD_O(acg), .POWER_GOOD_OUT_O(pg_out),
    .POWER_GOOD_OE_O(pg_oe), .PLUGGED_IN_N_O(pin_n), .STANDBY_PERMIT_OUT_O(pm_out),
    .STANDBY_PERMIT_OE_O(pm_oe), .SHARE_BUS_OUT_O(sh_out), .SHARE_BUS_OE_O(sh_oe),
    .TRIM_O(trim));
  psq_peer i_psq_peer (.permit_oe_i(pm_oe), .share_oe_i(sh_oe), .fault_i(pflt),
    .permit_line_o(pm), .share_line_o(sh));
  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // entered just after a rising edge; ack is seen as it stood at that edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    we <= w;
    wd <= d;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat;
    stb <= 1'b0;
    we <= 1'b0;
    chk(n < 50, "no bus answer");
    @(posedge clk);
  endtask
  // slack of a few cycles covers the input synchronisers
  task automatic wait_for(input int b, input logic v, input int lo, input int hi, input string m);
    int n;
    n = 0;
    while (obs[b] !== v && n <= hi * CPM) begin
      @(posedge clk);
      n++;
    end
    chk(n + 4 >= lo * CPM && n <= hi * CPM, m);
  endtask
  task automatic pat(input psq_pkg::psq_pat_type p, input int ny, input int ng, input string m);
    int cy;
    int cg;
    cy = 0;
    cg = 0;
    repeat (6) @(posedge clk);
    wb(psq_pkg::REG_STAT, 1'b0, 32'h0);
    chk(rd[14:12] === p, m);
    // one whole blink period: the counts hold whatever the slot phase
    repeat (PER) begin
      @(posedge clk);
      cy += int'(led_y === 1'b1);
      cg += int'(led_g === 1'b1);
    end
    chk(cy == ny && cg == ng, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic regs();
    wb(psq_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(rd === psq_pkg::CTRL_RST, "ctrl reset");
    wb(4'h8, 1'b1, 32'hFFFFFFFF);
    wb(4'h8, 1'b0, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    wb(psq_pkg::REG_CTRL, 1'b1, 32'h1);
    wb(psq_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(rd === 32'h1, "grant readback");
  endtask
  task automatic start_up();
    wait_for(3, 1'b1, 0, 2000, "ac good on");
    wait_for(1, 1'b1, 0, 2000, "aux start");
    wait_for(2, 1'b1, 10, 500, "main after aux");
    repeat (6) @(posedge clk);
    chk(pg_oe === 1'b0, "power good");
    repeat (20 * CPM) @(posedge clk);
    pat(psq_pkg::P_GREEN, 0, PER, "dc green");
    chk(rd[7] === 1'b1 && rd[11:8] === 4'h0 && trim === 4'h0, "share master");
  endtask
  task automatic warnings();
    warn <= 1'b1;
    fmin <= 1'b1;
    pat(psq_pkg::P_YG21, 2 * PER / 3, PER / 3, "warn first");
    warn <= 1'b0;
    pat(psq_pkg::P_YG11, PER / 2, PER / 2, "minor fan");
    fmin <= 1'b0;
  endtask
  task automatic kill_enable();
    kill <= 1'b1;
    wait_for(2, 1'b0, 0, 1, "kill main");
    chk(aux === 1'b1 && pg_oe === 1'b1, "aux kept");
    kill <= 1'b0;
    en_n <= 1'b1;
    pat(psq_pkg::P_Y11, PER / 2, 0, "disabled blink");
    repeat (10 * CPM) @(posedge clk);
    en_n <= 1'b0;
    wait_for(2, 1'b1, 980, 1200, "off time");
    en_n <= 1'b1;
    wait_for(2, 1'b0, 2, 20, "enable off");
    repeat (10 * CPM) @(posedge clk);
    en_n <= 1'b0;
    wait_for(2, 1'b1, 980, 1200, "restart");
  endtask
  task automatic faults();
    for (int i = 0; i < 4; i++) begin
      sd <= 4'h1 << i;
      repeat (5) @(posedge clk);
      sd <= 4'h0;
      pat(psq_pkg::P_YEL, PER, 0, "shutdown");
      chk(rd[4] === 1'b1 && pm_oe === 1'b1 && sh_oe === 1'b0, "latched");
      en_n <= 1'b1;
      repeat (10 * CPM) @(posedge clk);
      en_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk(pm_oe === 1'b0, "fault cleared");
    end
    wait_for(2, 1'b1, 900, 1200, "restart after fault");
  endtask
  task automatic sense_ilim();
    ilim <= 1'b1;
    uv <= 1'b1;
    wait_for(2, 1'b0, 0, 1, "limit inhibits main");
    chk(aux === 1'b1, "aux kept in limit");
    ilim <= 1'b0;
    uv <= 1'b0;
    ssc <= 1'b1;
    wait_for(1, 1'b0, 0, 1, "sense short");
    chk(pm_oe === 1'b1, "sense fault latched");
    ssc <= 1'b0;
    en_n <= 1'b1;
    repeat (10 * CPM) @(posedge clk);
    en_n <= 1'b0;
    wait_for(1, 1'b1, 980, 1200, "aux off time");
    wait_for(2, 1'b1, 10, 500, "main after restart");
  endtask
  task automatic standby();
    low <= 1'b1;
    wait_for(2, 1'b0, 0, 50, "standby entered");
    pat(psq_pkg::P_YG12, PER / 3, 2 * PER / 3, "standby blink");
    chk(rd[6] === 1'b1, "standby flag");
    pflt <= 1'b1;
    wait_for(2, 1'b1, 0, 20, "standby exit");
    pflt <= 1'b0;
    low <= 1'b0;
  endtask
  task automatic ac_loss();
    ac <= 1'b0;
    wait_for(3, 1'b0, 0, 5, "ac good off");
    wait_for(2, 1'b0, 7, 20, "main holdup");
    wait_for(1, 1'b0, 7, 20, "aux holdup");
    chk(ac_led === 1'b0, "ac led off");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    ac <= 1'b1;
    en_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(ac_led === 1'b1 && pin_n === 1'b0 && {pg_out, pm_out, sh_out} === 3'b000,
      "ac led or plug pin");
    regs();
    start_up();
    warnings();
    kill_enable();
    faults();
    sense_ilim();
    standby();
    ac_loss();
    close_out();
  end
endmodule
